//--- rtl/sbt_pkg.sv
// Package for the memory boundary-scan test port.
// Assumes a single system clock samples the slow test clock.
package sbt_pkg;

   // TAP controller states, one four-bit code per state
   typedef enum logic [3:0] {
      SBT_RESET      = 4'hF,
      SBT_IDLE       = 4'hC,
      SBT_SEL_DR     = 4'h7,
      SBT_CAP_DR     = 4'h6,
      SBT_SHIFT_DR   = 4'h2,
      SBT_EXIT1_DR   = 4'h1,
      SBT_PAUSE_DR   = 4'h3,
      SBT_EXIT2_DR   = 4'h0,
      SBT_UPDATE_DR  = 4'h5,
      SBT_SEL_IR     = 4'h4,
      SBT_CAP_IR     = 4'hE,
      SBT_SHIFT_IR   = 4'hA,
      SBT_EXIT1_IR   = 4'h9,
      SBT_PAUSE_IR   = 4'hB,
      SBT_EXIT2_IR   = 4'h8,
      SBT_UPDATE_IR  = 4'hD
   } sbt_state_type;

   // Instruction register
   localparam int          SBT_IR_W         = 3;
   localparam logic [2:0]  SBT_OP_EXTEST    = 3'h0;
   localparam logic [2:0]  SBT_OP_IDCODE    = 3'h1;
   localparam logic [2:0]  SBT_OP_SAMPLE_Z  = 3'h2;
   localparam logic [2:0]  SBT_OP_SAMPLE    = 3'h4;
   localparam logic [2:0]  SBT_OP_BYPASS    = 3'h7;
   localparam logic [2:0]  SBT_IR_RESET     = SBT_OP_IDCODE;
   localparam logic [1:0]  SBT_IR_CAPTURE   = 2'h1;

   // Data registers
   localparam int          SBT_ID_W         = 32;
   // Identification code; value is arbitrary
   localparam logic [31:0] SBT_ID_CODE      = 32'h0A5A5001;
   localparam int          SBT_BSR_W36      = 70;
   localparam int          SBT_BSR_W18      = 51;

   // Reset sequence length in TMS-high edges
   localparam int          SBT_RESET_EDGES  = 5;

endpackage

//--- rtl/sbt_sync.sv
// Two-stage synchroniser for one pin input.
// Assumes the input is asynchronous to clock_in; reset value is given.
`timescale 1ns/1ps
module sbt_sync #(
   parameter logic INIT = 1'b0
) (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   // Data
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_reg;

   // First stage is read only by the second
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         meta_reg <= INIT;
         q_out    <= INIT;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule

//--- rtl/sbt_tap.sv
// Boundary-scan test access port of a burst memory.
// Assumes clock_in is far faster than the test clock; the test clock,
// TMS and TDI are pins and are synchronised before use.
// Operation
// - TAP, IR, BSR, bypass, ID registers, test clock
// - Reset state leaves memory operation untouched
// - Controller steps on TMS at rising edge
// - Sample on rise, update TDO and its enable on fall
// - Open TMS and TDI read high; code has no pull-ups, only resets their synchronisers high
// - Instruction picks the single scan register
// - TDI into MSB, TDO from LSB
// - TDO driven only while shifting
// - Five TMS-high edges reach reset
// - Test reset never disturbs memory accesses
// - Power-up reset leaves TDO floating
// - Three-bit IR loaded serially
// - IR holds identification code after reset
// - Capture-IR loads 01 into low bits
// - Bypass is one stage, one delay
// - Bypass cleared under bypass instruction
// - ID register captures and shifts code
// - BSR is 70 or 51 stages
// - All-zeros samples and floats memory outputs
// - Sample-Z selects BSR, floats outputs
`timescale 1ns/1ps
module sbt_tap (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   // Configuration: high selects the 36-bit-wide ring
   input  wire logic         wide_cfg_in,
   // Test pins
   input  wire logic         tck_in,
   input  wire logic         tms_in,
   input  wire logic         tdi_in,
   output logic              tdo_out,
   output logic              tdo_oe_n_out,
   // Pin ring snapshot and memory output control
   input  wire logic [69:0]  ring_in,
   output logic              mem_hiz_out,
   // Observation
   output sbt_pkg::sbt_state_type state_out
);
   import sbt_pkg::*;

   // Synchronised pins and test clock edges
   logic          tck_s;
   logic          tms_s;
   logic          tdi_s;
   logic          wide_s;
   logic [69:0]   ring_s;
   logic          tck_d_reg;
   logic          rise;
   logic          fall;

   // Controller and instruction
   sbt_state_type state_reg;
   sbt_state_type state_next;
   logic [2:0]    ir_reg;
   logic [2:0]    op_reg;
   logic          float_op;

   // Data registers
   logic          byp_reg;
   logic [31:0]   id_reg;
   logic [69:0]   bsr_reg;
   logic [69:0]   bsr_shift;

   // Scan path control
   logic          shift_dr;
   logic          shift_ir;
   logic          sel_bsr;
   logic          sel_id;
   logic          scan_bit;
   logic [6:0]    bsr_msb;

   sbt_sync #(.INIT(1'b1)) u_sync_tms (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .d_in     (tms_in),
      .q_out    (tms_s)
   );
   sbt_sync #(.INIT(1'b1)) u_sync_tdi (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .d_in     (tdi_in),
      .q_out    (tdi_s)
   );
   // A test clock held low never produces an edge
   sbt_sync #(.INIT(1'b0)) u_sync_tck (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .d_in     (tck_in),
      .q_out    (tck_s)
   );

   // Ring and width strap are pins too; a ring bit that moves during
   // capture may still land either way, but never goes metastable inside
   for (genvar g = 0; g < 70; g++) begin : g_ring_sync
      sbt_sync #(.INIT(1'b0)) u_sync_ring (
         .clock_in (clock_in),
         .rst_n_in (rst_n_in),
         .d_in     (ring_in[g]),
         .q_out    (ring_s[g])
      );
   end
   sbt_sync #(.INIT(1'b1)) u_sync_wide (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .d_in     (wide_cfg_in),
      .q_out    (wide_s)
   );

   // Test clock edge detection
   // Edges are seen three clocks late, so each test clock phase must
   // last at least four clocks for TMS and TDI to line up with them
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         tck_d_reg <= 1'b0;
      end else begin
         tck_d_reg <= tck_s;
      end
   end
   assign rise = tck_s & ~tck_d_reg;
   assign fall = ~tck_s & tck_d_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SBT_RESET:     state_next = tms_s ? SBT_RESET : SBT_IDLE;
         SBT_IDLE:      state_next = tms_s ? SBT_SEL_DR : SBT_IDLE;
         SBT_SEL_DR:    state_next = tms_s ? SBT_SEL_IR : SBT_CAP_DR;
         SBT_CAP_DR:    state_next = tms_s ? SBT_EXIT1_DR : SBT_SHIFT_DR;
         SBT_SHIFT_DR:  state_next = tms_s ? SBT_EXIT1_DR : SBT_SHIFT_DR;
         SBT_EXIT1_DR:  state_next = tms_s ? SBT_UPDATE_DR : SBT_PAUSE_DR;
         SBT_PAUSE_DR:  state_next = tms_s ? SBT_EXIT2_DR : SBT_PAUSE_DR;
         SBT_EXIT2_DR:  state_next = tms_s ? SBT_UPDATE_DR : SBT_SHIFT_DR;
         SBT_UPDATE_DR: state_next = tms_s ? SBT_SEL_DR : SBT_IDLE;
         SBT_SEL_IR:    state_next = tms_s ? SBT_RESET : SBT_CAP_IR;
         SBT_CAP_IR:    state_next = tms_s ? SBT_EXIT1_IR : SBT_SHIFT_IR;
         SBT_SHIFT_IR:  state_next = tms_s ? SBT_EXIT1_IR : SBT_SHIFT_IR;
         SBT_EXIT1_IR:  state_next = tms_s ? SBT_UPDATE_IR : SBT_PAUSE_IR;
         SBT_PAUSE_IR:  state_next = tms_s ? SBT_EXIT2_IR : SBT_PAUSE_IR;
         SBT_EXIT2_IR:  state_next = tms_s ? SBT_UPDATE_IR : SBT_SHIFT_IR;
         SBT_UPDATE_IR: state_next = tms_s ? SBT_SEL_DR : SBT_IDLE;
         default:       state_next = SBT_RESET;
      endcase
   end

   // Step on rising edge; five TMS-high edges end in reset
   // power-up reset puts the controller in reset
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_reg <= SBT_RESET;
      end else if (rise) begin
         state_reg <= state_next;
      end
   end

   assign shift_dr = (state_reg == SBT_SHIFT_DR);
   assign shift_ir = (state_reg == SBT_SHIFT_IR);

   // Serial IR shift; capture 01; reload code
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ir_reg <= SBT_IR_RESET;
      end else if (rise) begin
         case (state_reg)
            SBT_RESET:  ir_reg <= SBT_IR_RESET;
            SBT_CAP_IR: ir_reg <= {ir_reg[2], SBT_IR_CAPTURE};
            SBT_SHIFT_IR: ir_reg <= {tdi_s, ir_reg[2:1]};
            default:    ir_reg <= ir_reg;
         endcase
      end
   end

   // Code reloads on the edge that enters reset, so no floating
   // instruction survives into the reset state
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         op_reg <= SBT_IR_RESET;
      end else if (rise) begin
         if (state_next == SBT_RESET) begin
            op_reg <= SBT_IR_RESET;
         end else if (state_reg == SBT_UPDATE_IR) begin
            op_reg <= ir_reg;
         end
      end
   end

   // Instruction decode; unknown codes fall to bypass
   always_comb begin
      sel_bsr = 1'b0;
      sel_id  = 1'b0;
      case (op_reg)
         SBT_OP_EXTEST,
         SBT_OP_SAMPLE_Z,
         SBT_OP_SAMPLE: sel_bsr = 1'b1;
         SBT_OP_IDCODE: sel_id  = 1'b1;
         default:       sel_bsr = 1'b0;
      endcase
   end

   // Single bypass stage; cleared on capture
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         byp_reg <= 1'b0;
      end else if (rise && !sel_bsr && !sel_id) begin
         if (state_reg == SBT_CAP_DR) begin
            byp_reg <= 1'b0;
         end else if (shift_dr) begin
            byp_reg <= tdi_s;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         id_reg <= SBT_ID_CODE;
      end else if (rise && sel_id) begin
         if (state_reg == SBT_CAP_DR) begin
            id_reg <= SBT_ID_CODE;
         end else if (shift_dr) begin
            id_reg <= {tdi_s, id_reg[31:1]};
         end
      end
   end

   // Ring length follows configuration; TDI enters the top stage
   assign bsr_msb = wide_s ? 7'(SBT_BSR_W36 - 1) : 7'(SBT_BSR_W18 - 1);
   assign bsr_shift = {1'b0, bsr_reg[69:1]};

   // Capture samples the ring; preload is not supported
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         bsr_reg <= 70'h0;
      end else if (rise && sel_bsr) begin
         if (state_reg == SBT_CAP_DR) begin
            bsr_reg <= wide_s ? ring_s
                              : {19'h0, ring_s[SBT_BSR_W18-1:0]};
         end else if (shift_dr) begin
            // Shift toward the LSB, TDI into the top stage
            for (int i = 0; i < 70; i++) begin
               if (7'(i) == bsr_msb) begin
                  bsr_reg[i] <= tdi_s;
               end else begin
                  bsr_reg[i] <= bsr_shift[i];
               end
            end
         end
      end
   end

   // Only the selected register reaches TDO; LSB first
   always_comb begin
      if (shift_ir) begin
         scan_bit = ir_reg[0];
      end else if (sel_bsr) begin
         scan_bit = bsr_reg[0];
      end else if (sel_id) begin
         scan_bit = id_reg[0];
      end else begin
         scan_bit = byp_reg;
      end
   end

   // Outputs change on falling edge; floated outside shifts
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         tdo_out      <= 1'b0;
         tdo_oe_n_out <= 1'b1;
      end else if (fall) begin
         tdo_out      <= scan_bit;
         tdo_oe_n_out <= ~(shift_dr | shift_ir);
      end
   end

   // All-zeros and sample-Z both float the memory outputs
   assign float_op = (op_reg == SBT_OP_EXTEST) ||
                     (op_reg == SBT_OP_SAMPLE_Z);

   // Reset state never floats memory outputs; registered
   // so the memory side sees one clean level per instruction
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         mem_hiz_out <= 1'b0;
      end else begin
         mem_hiz_out <= float_op;
      end
   end

   // Controller state for observation
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_out <= SBT_RESET;
      end else begin
         state_out <= state_reg;
      end
   end
endmodule

//--- verif/sbt_tap_checker.sv
// Concurrent checks on the ports of the boundary-scan test port.
// Assumes the test clock is far slower than clock_in.
`timescale 1ns/1ps
module sbt_tap_checker
   import sbt_pkg::*;
(
   // Clock and reset
   input wire logic            clock_in,
   input wire logic            rst_n_in,
   // Test pins, ring and controls
   input wire logic            wide_cfg_in,
   input wire logic            tck_in,
   input wire logic            tms_in,
   input wire logic            tdi_in,
   input wire logic            tdo_out,
   input wire logic            tdo_oe_n_out,
   input wire logic [69:0]     ring_in,
   input wire logic            mem_hiz_out,
   input sbt_pkg::sbt_state_type state_out
);
   logic       tck_q_reg;
   logic [2:0] ones_reg;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   // Raw TCK rises seen with TMS high; saturates so five stays five
   always_ff @(posedge clock_in) begin
      tck_q_reg <= tck_in;
      if (!rst_n_in) begin
         ones_reg <= 3'h0;
      end else if (tck_in && !tck_q_reg) begin
         ones_reg <= !tms_in ? 3'h0 : (ones_reg == 3'h5) ? 3'h5
                                    : ones_reg + 3'h1;
      end
   end

   chk_reset_out: assert property (disable iff (1'b0) !rst_n_in [*3] |->
      state_out == SBT_RESET && tdo_oe_n_out && !mem_hiz_out)
      else $error("outputs not at reset values");
   chk_five_ones: assert property ($rose(ones_reg == 3'h5) |->
      ##[0:8] state_out == SBT_RESET) else $error("TMS reset missed");
   chk_step_rise: assert property ($changed(state_out) |-> tck_in)
      else $error("state moved outside TCK high phase");
   chk_tdo_fall: assert property ($changed(tdo_out) |-> !tck_in)
      else $error("TDO changed outside TCK low phase");
   chk_oe_fall: assert property ($changed(tdo_oe_n_out) |-> !tck_in)
      else $error("TDO enable changed outside TCK low phase");
   chk_oe_shift: assert property (!tdo_oe_n_out |-> state_out inside
      {SBT_SHIFT_DR, SBT_SHIFT_IR, SBT_EXIT1_DR, SBT_EXIT1_IR})
      else $error("TDO driven outside shifting");
   chk_oe_idle: assert property (state_out == SBT_IDLE [*8] |->
      tdo_oe_n_out) else $error("TDO driven in idle");
   chk_hiz_update: assert property ($changed(mem_hiz_out) |-> ##[0:2]
      state_out inside {SBT_UPDATE_IR, SBT_IDLE, SBT_SEL_DR, SBT_RESET})
      else $error("float control changed away from update");
   chk_hiz_reset: assert property (state_out == SBT_RESET [*3] |->
      !mem_hiz_out) else $error("outputs floated in reset");
endmodule

bind sbt_tap sbt_tap_checker u_chk (
   .clock_in, .rst_n_in, .wide_cfg_in, .tck_in, .tms_in, .tdi_in,
   .tdo_out, .tdo_oe_n_out, .ring_in, .mem_hiz_out, .state_out
);

//--- verif/sbt_host_model.sv
// Model of the external test controller on the test pins.
// Assumes one caller at a time, starting each scan from Idle.
`timescale 1ns/1ps
module sbt_host_model (
   // Test pins
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   input  wire logic tdo_in
);
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end
   // One period; TDO read before the rise, lines held to the next
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #32;
      tdo = tdo_in;
      tck_out = 1'b1;
      #32;
      tck_out = 1'b0;
   endtask
   // Five TMS-high rises, then on to Idle
   task automatic to_idle();
      logic t;
      repeat (5) step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
   endtask
   // Capture, Shift, Exit1, Update and back to Idle
   task automatic scan(input logic ir, input int n,
                       input logic [69:0] din, output logic [69:0] dout);
      logic t;
      dout = '0;
      step(1'b1, 1'b1, t);
      if (ir) step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
      step(1'b0, 1'b1, t);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], t);
         dout[i] = t;
      end
      step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
   endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the host model drives the pins and the checker is bound.
`timescale 1ns/1ps
module tb;
   import sbt_pkg::*;
   logic          clock_in, rst_n_in, wide_cfg_in;
   logic [69:0]   ring_in, got;
   logic [2:0]    byp_ops [4] = '{3'h3, 3'h5, 3'h6, SBT_OP_BYPASS};
   wire logic     tck, tms, tdi, tdo_out, tdo_oe_n_out, mem_hiz_out;
   wire logic     tdo_pin;
   wire sbt_state_type state_out;
   int            err_count = 0;
   int            checks_done = 0;
   int            cycles = 0;

   sbt_tap u_dut (
      .clock_in, .rst_n_in, .wide_cfg_in, .tck_in(tck), .tms_in(tms),
      .tdi_in(tdi), .tdo_out, .tdo_oe_n_out, .ring_in, .mem_hiz_out,
      .state_out
   );
   sbt_host_model u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
                          .tdo_in(tdo_pin));
   // Pin floats when not enabled, so a stale bit cannot pass
   assign tdo_pin = tdo_oe_n_out ? 1'bz : tdo_out;

   // System clock, 5 ns
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   // Hang guard, well above the few thousand cycles needed
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   task automatic chk(input logic [69:0] seen, input logic [69:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic load_ir(input logic [2:0] op);
      u_host.scan(1'b1, 3, {67'h0, op}, got);
   endtask

   task automatic s_power();
      chk(state_out, SBT_RESET);
      chk(tdo_oe_n_out, 1'b1);
      chk(mem_hiz_out, 1'b0);
   endtask
   task automatic s_idcode();
      u_host.to_idle();
      chk(mem_hiz_out, 1'b0);
      u_host.scan(1'b0, 40, 70'hC6, got);
      chk(got[31:0], SBT_ID_CODE);
      chk(got[69:32], 38'hC6);
   endtask
   task automatic s_ir();
      load_ir(SBT_OP_BYPASS);
      chk(got, 70'h1);
      load_ir(SBT_OP_BYPASS);
      chk(got, 70'h5);
   endtask
   // First bit out is the cleared stage, then TDI one period late
   task automatic s_bypass(input logic [2:0] op);
      load_ir(op);
      u_host.scan(1'b0, 8, 70'hB5, got);
      chk(got, 70'h6A);
      chk(mem_hiz_out, 1'b0);
   endtask
   task automatic s_ring(input logic [2:0] op, input logic wide,
                         input logic hiz);
      @(negedge clock_in);
      wide_cfg_in = wide;
      load_ir(op);
      chk(mem_hiz_out, hiz);
      u_host.scan(1'b0, wide ? 70 : 51, 70'h0, got);
      chk(got, wide ? ring_in : {19'h0, ring_in[50:0]});
   endtask

   // Reset, then the scenarios in turn
   initial begin
      rst_n_in = 1'b0;
      wide_cfg_in = 1'b1;
      ring_in = {2'h2, 68'h2_A5A5_C3C3_0F0F_1234};
      repeat (4) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clock_in);
      s_power();
      s_idcode();
      s_ir();
      foreach (byp_ops[i]) s_bypass(byp_ops[i]);
      s_ring(SBT_OP_EXTEST, 1'b1, 1'b1);
      s_ring(SBT_OP_SAMPLE_Z, 1'b0, 1'b1);
      s_ring(SBT_OP_SAMPLE, 1'b1, 1'b0);
      s_ring(SBT_OP_SAMPLE, 1'b0, 1'b0);
      s_ring(SBT_OP_EXTEST, 1'b0, 1'b1);
      s_idcode();
      final_report();
   end
endmodule
